/* shared/rsbc_defs.vh */
// Constants for the reset source and brown-out control block
`ifndef RSBC_DEFS_VH
`define RSBC_DEFS_VH
`define RSBC_ADDR_BROWNOUT_CONTROL 12'h000
`define RSBC_ADDR_RESET_CAUSE      12'h004
`define RSBC_BIT_SW_BROWNOUT_EN    7
`define RSBC_BIT_BROWNOUT_READY    0
`define RSBC_RST_SW_BROWNOUT_EN    1'b1
`define RSBC_MODE_OFF              2'b00
`define RSBC_MODE_SOFTWARE         2'b01
`define RSBC_MODE_AWAKE_ONLY       2'b10
`define RSBC_MODE_ALWAYS           2'b11
`define RSBC_CLK_MHZ               250
`define RSBC_PWRUP_DELAY_MS        64
`define RSBC_PWRUP_DELAY_CYC       (`RSBC_PWRUP_DELAY_MS * 1000 * `RSBC_CLK_MHZ)
`define RSBC_CLEAR_RELEASE_CYC     10
`define RSBC_BO_FILTER_CYC         16
`define RSBC_CLR_FILTER_CYC        8
`endif

/* hdl/rsbc_reset_control.v */
// Reset source gathering, brown-out modes and brown-out control register
//
// Contract
// (RULE1) Eight reset sources can reset the core
// (RULE2) Optional power-up delay extends power/brown-out reset
// (RULE3) Hold reset while supply below minimum
// (RULE4) One bit picks threshold; low supply resets
// (RULE5) Only dips longer than filter cause reset
// (RULE6) Mode 11: always on, waits ready
// (RULE7) Mode 10: off in sleep, waits ready
// (RULE8) Mode 10: no protection during sleep
// (RULE9) Mode 01: software bit switches monitor
// (RULE10) Software mode protects only once ready
// (RULE11) Mode 00: monitor off, no waiting
// (RULE12) Always-on: ready already one at start
// (RULE13) Bit 0 reads monitor active status
// (RULE14) Bit 7 always read/write, else inert
// (RULE15) Clear pin enabled by enable or LOW_VOLTAGE_PROGRAMMING_CFG
// (RULE16) Reset held while enabled pin low
// (RULE17) Filter rejects short pulses on clear pin
// (RULE18) Clear pin is never driven
// (RULE19) Disabled pin is GPIO, pull-up by software
// (RULE20) Delay timer enabled by zero, 64 ms
// (RULE21) Run ten cycles after clear pin release
// (RULE22) Sync monitor inputs; synchronous release
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "rsbc_defs.vh"

module rsbc_reset_control #(
   parameter PWRUP_CYC = `RSBC_PWRUP_DELAY_CYC,
   parameter BO_FILT   = `RSBC_BO_FILTER_CYC,
   parameter CLR_FILT  = `RSBC_CLR_FILTER_CYC
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        clkEn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire [1:0]  brownoutModeCfg,
   input  wire        brownoutLevelSelect,
   input  wire        powerupDelayDisableCfg,
   input  wire        clearPinEnableCfg,
   input  wire        lowVoltageProgrammingCfg,
   input  wire        powerGoodIn,
   input  wire        supplyBelowLowLvlIn,
   input  wire        supplyBelowHighLvlIn,
   input  wire        monitorReadyIn,
   input  wire        externalClearPinIn,
   input  wire        gpioPullupSw,
   input  wire        sleepMode,
   input  wire        watchdogReset,
   input  wire        resetInstruction,
   input  wire        stackOverflow,
   input  wire        stackUnderflow,
   input  wire        programmingExit,
   output wire        monitorEnable,
   output wire        clearPinOut,
   output wire        clearPinOe,
   output wire        clearPinPullup,
   output wire        clearPinGpio,
   output reg         coreReset
);

   // ************************************************
   // Synchronisers: change counts when stages 2 and 3 agree
   // ************************************************
   reg [2:0] pgSync_r;
   reg [2:0] lowSync_r;
   reg [2:0] highSync_r;
   reg [2:0] rdySync_r;
   reg [2:0] clrSync_r;
   reg       powerGood_r;
   reg       belowLow_r;
   reg       belowHigh_r;
   reg       monReady_r;
   reg       clrPin_r;

   // A disagreement between the last two stages is an unsettled sample; keep the old value
   function syncAccept;
      input [2:0] stages;
      input       current;
      begin
         syncAccept = (stages[2] == stages[1]) ? stages[2] : current;
      end
   endfunction

   always @(posedge clk) begin
      if (rst) begin
         pgSync_r    <= 3'h0;
         lowSync_r   <= 3'h0;
         highSync_r  <= 3'h0;
         rdySync_r   <= 3'h0;
         clrSync_r   <= 3'h7;
         powerGood_r <= 1'b0;
         belowLow_r  <= 1'b0;
         belowHigh_r <= 1'b0;
         monReady_r  <= 1'b0;
         clrPin_r    <= 1'b1;
      end else if (clkEn) begin
         pgSync_r   <= {pgSync_r[1:0], powerGoodIn};        // RULE22
         lowSync_r  <= {lowSync_r[1:0], supplyBelowLowLvlIn};
         highSync_r <= {highSync_r[1:0], supplyBelowHighLvlIn};
         rdySync_r  <= {rdySync_r[1:0], monitorReadyIn};
         clrSync_r  <= {clrSync_r[1:0], externalClearPinIn};
         powerGood_r <= syncAccept(pgSync_r, powerGood_r);
         belowLow_r  <= syncAccept(lowSync_r, belowLow_r);
         belowHigh_r <= syncAccept(highSync_r, belowHigh_r);
         monReady_r  <= syncAccept(rdySync_r, monReady_r);
         clrPin_r    <= syncAccept(clrSync_r, clrPin_r);
      end
   end

   // ************************************************
   // Register and mode decode
   // ************************************************
   reg        swBrownoutEn_r;
   reg  [7:0] resetCause_r;
   wire       brownoutReadyStatus;
   wire       monitorOn;
   wire       waitReady;
   wire       setupPh  = psel & ~penable;
   wire       accessWr = psel & penable & pwrite;
   wire       hitCtl   = (paddr == `RSBC_ADDR_BROWNOUT_CONTROL);
   wire       hitCause = (paddr == `RSBC_ADDR_RESET_CAUSE);
   wire       modeAlways = (brownoutModeCfg == `RSBC_MODE_ALWAYS);
   wire       modeAwake  = (brownoutModeCfg == `RSBC_MODE_AWAKE_ONLY);
   wire       modeSoft   = (brownoutModeCfg == `RSBC_MODE_SOFTWARE);

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hitCtl & ~hitCause;

   // Monitor power: software mode uses bit 7, other modes ignore it
   assign monitorOn =
      modeAlways |                                                        // RULE6
      (modeAwake & ~sleepMode) |                                          // RULE7 RULE8
      (modeSoft & swBrownoutEn_r);                                        // RULE9 RULE14 RULE11
   assign monitorEnable = monitorOn;
   assign brownoutReadyStatus = monitorOn & monReady_r;                   // RULE13

   // Only the hardware-forced modes gate start-up on readiness
   assign waitReady = brownoutModeCfg[1];                                 // RULE6 RULE7 RULE11 RULE12

   always @(posedge clk) begin
      if (rst) begin
         swBrownoutEn_r <= `RSBC_RST_SW_BROWNOUT_EN;
      end else if (clkEn && accessWr && hitCtl) begin
         swBrownoutEn_r <= pwdata[`RSBC_BIT_SW_BROWNOUT_EN];              // RULE14
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (clkEn && setupPh) begin
         prdata <= 32'h00000000;
         if (hitCtl) begin
            prdata[`RSBC_BIT_SW_BROWNOUT_EN] <= swBrownoutEn_r;
            prdata[`RSBC_BIT_BROWNOUT_READY] <= brownoutReadyStatus;       // RULE13
         end else if (hitCause) begin
            prdata[7:0] <= resetCause_r;
         end
      end
   end

   // ************************************************
   // Brown-out filter
   // ************************************************
   reg  [15:0] boCnt_r;
   reg         brownoutReset_r;
   // Protection only when monitor powered and reporting ready
   wire belowSel = brownoutLevelSelect ? belowHigh_r : belowLow_r;        // RULE4
   wire boActive = brownoutReadyStatus & belowSel;                        // RULE10

   always @(posedge clk) begin
      if (rst) begin
         boCnt_r         <= 16'h0000;
         brownoutReset_r <= 1'b0;
      end else if (clkEn) begin
         if (!boActive) begin
            boCnt_r         <= 16'h0000;
            brownoutReset_r <= 1'b0;
         end else if (boCnt_r >= BO_FILT[15:0]) begin
            brownoutReset_r <= 1'b1;                                      // RULE5
         end else begin
            boCnt_r <= boCnt_r + 16'h0001;
         end
      end
   end

   // ************************************************
   // Clear pin path; pin is input only
   // ************************************************
   reg  [7:0] clrCnt_r;
   reg        clrLow_r;
   wire       clearEnabled = clearPinEnableCfg | lowVoltageProgrammingCfg; // RULE15

   assign clearPinOut    = 1'b0;                                          // RULE18
   assign clearPinOe     = 1'b0;                                          // RULE18
   assign clearPinGpio   = ~clearEnabled;                                 // RULE19
   assign clearPinPullup = clearEnabled ? 1'b1 : gpioPullupSw;            // RULE19

   // Low must persist for the filter length before it counts
   always @(posedge clk) begin
      if (rst) begin
         clrCnt_r <= 8'h00;
         clrLow_r <= 1'b0;
      end else if (clkEn) begin
         if (!clearEnabled || clrPin_r) begin
            clrCnt_r <= 8'h00;
            clrLow_r <= 1'b0;
         end else if (clrCnt_r >= CLR_FILT[7:0]) begin
            clrLow_r <= 1'b1;                                             // RULE16 RULE17
         end else begin
            clrCnt_r <= clrCnt_r + 8'h01;
         end
      end
   end

   // ************************************************
   // Wake-up gating
   // ************************************************
   // Mode 10 powers the monitor down in sleep, so after waking the core is
   // held until the monitor is ready again; a plain hold, not a power-up,
   // so the power-up delay is not rerun and supply dips stay filtered.
   reg        wakeWait_r;
   wire       wakeStall = wakeWait_r & ~sleepMode & ~brownoutReadyStatus;

   always @(posedge clk) begin
      if (rst) begin
         wakeWait_r <= 1'b0;
      end else if (clkEn) begin
         if (modeAwake && sleepMode) begin
            wakeWait_r <= 1'b1;                                           // RULE7
         end else if (brownoutReadyStatus || !modeAwake) begin
            wakeWait_r <= 1'b0;
         end
      end
   end

   // ************************************************
   // Release sequencer
   // ************************************************
   localparam ST_POWER = 2'd0;
   localparam ST_DELAY = 2'd1;
   localparam ST_CLEAR = 2'd2;
   localparam ST_RUN   = 2'd3;

   reg [1:0]  state_r;
   reg [31:0] cnt_r;
   wire       supplyFault = ~powerGood_r | brownoutReset_r;               // RULE3 RULE4
   wire       readyOk     = ~waitReady | (brownoutReadyStatus & ~belowSel);
   wire       softSrc     = watchdogReset | resetInstruction | stackOverflow |
                            stackUnderflow;                               // RULE1

   always @(posedge clk) begin
      if (rst) begin
         state_r      <= ST_POWER;
         cnt_r        <= 32'h00000000;
         coreReset    <= 1'b1;
      end else if (clkEn) begin
         if (supplyFault || programmingExit) begin
            // Programming exit behaves like a fresh power-on
            state_r   <= ST_POWER;                                        // RULE1
            coreReset <= 1'b1;
            cnt_r     <= 32'h00000000;
         end else begin
            case (state_r)
               ST_POWER: begin
                  coreReset <= 1'b1;
                  cnt_r     <= 32'h00000000;
                  if (readyOk)
                     state_r <= powerupDelayDisableCfg ? ST_CLEAR : ST_DELAY; // RULE2 RULE20
               end
               ST_DELAY: begin
                  // Runs regardless of the clear pin
                  coreReset <= 1'b1;
                  if (cnt_r >= PWRUP_CYC - 1) begin
                     cnt_r   <= 32'h00000000;
                     state_r <= ST_CLEAR;                                 // RULE20
                  end else begin
                     cnt_r <= cnt_r + 32'h00000001;
                  end
               end
               ST_CLEAR: begin
                  coreReset <= 1'b1;
                  if (clrLow_r) begin
                     cnt_r <= 32'h00000000;                               // RULE16
                  end else if (cnt_r >= `RSBC_CLEAR_RELEASE_CYC - 1) begin
                     state_r   <= ST_RUN;                                 // RULE21
                     coreReset <= 1'b0;
                  end else begin
                     cnt_r <= cnt_r + 32'h00000001;
                  end
               end
               ST_RUN: begin
                  if (clrLow_r || softSrc) begin
                     state_r   <= ST_CLEAR;                               // RULE1 RULE16
                     coreReset <= 1'b1;
                     cnt_r     <= 32'h00000000;
                  end else if (wakeStall) begin
                     coreReset <= 1'b1;                                   // RULE7
                  end else begin
                     coreReset <= 1'b0;
                  end
               end
               default: begin
                  state_r   <= ST_POWER;
                  coreReset <= 1'b1;
               end
            endcase
         end
      end
   end

   // ************************************************
   // Reset cause record
   // ************************************************
   // Each event group rewrites only its own bits, so a cause stays
   // visible to software after the core has restarted.
   wire runEvent = (state_r == ST_RUN) & (clrLow_r | softSrc);

   always @(posedge clk) begin
      if (rst) begin
         resetCause_r <= 8'h00;
      end else if (clkEn) begin
         if (supplyFault || programmingExit) begin
            resetCause_r[0] <= brownoutReset_r;
            resetCause_r[1] <= ~powerGood_r | programmingExit;            // RULE1
         end else if (runEvent) begin
            resetCause_r[2] <= clrLow_r;
            resetCause_r[3] <= watchdogReset;
            resetCause_r[4] <= resetInstruction;
            resetCause_r[5] <= stackOverflow;
            resetCause_r[6] <= stackUnderflow;
         end
      end
   end

endmodule // rsbc_reset_control

/* sim/rsbc_checker.sv */
// Port assertions for the reset source and brown-out block
`timescale 1ns/1ns
module rsbc_checker (
   input wire       clk,
   input wire       rst,
   input wire [1:0] brownoutModeCfg,
   input wire       clearPinEnableCfg,
   input wire       lowVoltageProgrammingCfg,
   input wire       powerGoodIn,
   input wire       externalClearPinIn,
   input wire       gpioPullupSw,
   input wire       sleepMode,
   input wire       watchdogReset,
   input wire       monitorEnable,
   input wire       clearPinOut,
   input wire       clearPinOe,
   input wire       clearPinPullup,
   input wire       clearPinGpio,
   input wire       coreReset
);
   wire pinOn = clearPinEnableCfg | lowVoltageProgrammingCfg;
   wire pinHeld = pinOn & ~externalClearPinIn;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_pin_input_only: assert property (!clearPinOe && !clearPinOut) else $error("pin driven");
   a_gpio_select: assert property (clearPinGpio == !pinOn) else $error("pin function");
   a_pullup_soft: assert property (clearPinGpio |-> clearPinPullup == gpioPullupSw) else $error("pull-up");
   a_mode_off: assert property (brownoutModeCfg == 2'h0 |-> !monitorEnable) else $error("mode off");
   a_mode_always: assert property (brownoutModeCfg == 2'h3 |-> monitorEnable) else $error("mode always");
   a_awake_only: assert property (brownoutModeCfg == 2'h2 |-> monitorEnable == !sleepMode) else $error("mode awake");
   a_power_hold: assert property (!powerGoodIn [*6] |-> coreReset) else $error("ran unpowered");
   a_source_reset: assert property ($rose(watchdogReset) |-> ##[1:4] coreReset) else $error("wdt ignored");
   a_pin_hold: assert property (pinHeld [*8] ##1 pinHeld [*7] |-> coreReset) else $error("pin ignored");
   a_pin_release: assert property ($fell(coreReset) && pinOn |-> $past(externalClearPinIn, 10)) else $error("early run");
   c_release: cover property ($fell(coreReset));
   c_sleep_off: cover property (sleepMode && brownoutModeCfg == 2'h2);
   c_pin_gpio: cover property (clearPinGpio && !externalClearPinIn);
endmodule // rsbc_checker

bind rsbc_reset_control rsbc_checker u_chk (.clk(clk), .rst(rst), .brownoutModeCfg(brownoutModeCfg),
   .clearPinEnableCfg(clearPinEnableCfg), .lowVoltageProgrammingCfg(lowVoltageProgrammingCfg),
   .powerGoodIn(powerGoodIn), .externalClearPinIn(externalClearPinIn), .gpioPullupSw(gpioPullupSw),
   .sleepMode(sleepMode), .watchdogReset(watchdogReset), .monitorEnable(monitorEnable), .clearPinOut(clearPinOut),
   .clearPinOe(clearPinOe), .clearPinPullup(clearPinPullup), .clearPinGpio(clearPinGpio), .coreReset(coreReset));

/* sim/rsbc_supply_model.sv */
// Model of the supply monitors and the external clear pin
`timescale 1ns/1ns
module rsbc_supply_model #(
   parameter READY_DLY = 5
) (
   input  wire       clk,
   input  wire       powerOn,
   input  wire [1:0] dipDepth,
   input  wire       pinLow,
   input  wire       monitorEnable,
   output wire       powerGoodIn,
   output wire       supplyBelowLowLvlIn,
   output wire       supplyBelowHighLvlIn,
   output wire       monitorReadyIn,
   output wire       externalClearPinIn
);
   reg [3:0] readyCnt = 4'h0;
   assign powerGoodIn = powerOn;
   // Depth 1 crosses only the high level, depth 2 both
   assign supplyBelowHighLvlIn = !powerOn || dipDepth != 2'h0;
   assign supplyBelowLowLvlIn = !powerOn || dipDepth == 2'h2;
   assign monitorReadyIn = readyCnt == READY_DLY;
   // Weak pull-up lifts the pin when nobody pulls it
   assign externalClearPinIn = !pinLow;
   // Ready lags the enable so protection cannot start at once
   always @(posedge clk) begin
      if (!monitorEnable)
         readyCnt <= 4'h0;
      else if (readyCnt != READY_DLY)
         readyCnt <= readyCnt + 4'h1;
   end
endmodule // rsbc_supply_model

/* sim/tb.sv */
// Self-checking bench for the reset source and brown-out block
`timescale 1ns/1ns
`include "rsbc_defs.vh"
module tb;
   localparam CTRL = `RSBC_ADDR_BROWNOUT_CONTROL;
   reg clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
   reg powerOn = 0, pinLow = 0, lvl = 0, pwrDis = 0, clrEn = 1, low_voltage_programming_cfg = 0, pull = 0, sleep = 0;
   reg [1:0] mode = 2'h3, dip = 2'h0;
   reg [4:0] src = 5'h00;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, rd;
   wire [31:0] prdata;
   wire pready, pslverr, monEn, pg, bLow, bHigh, rdy, pin, coreReset;
   int nFail = 0, nChecks = 0;
   initial forever #2 clk = ~clk;
   rsbc_reset_control #(.PWRUP_CYC(20)) dut (.clk(clk), .rst(rst), .clkEn(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .brownoutModeCfg(mode), .brownoutLevelSelect(lvl), .powerupDelayDisableCfg(pwrDis),
      .clearPinEnableCfg(clrEn), .lowVoltageProgrammingCfg(low_voltage_programming_cfg), .powerGoodIn(pg), .supplyBelowLowLvlIn(bLow),
      .supplyBelowHighLvlIn(bHigh), .monitorReadyIn(rdy), .externalClearPinIn(pin), .gpioPullupSw(pull),
      .sleepMode(sleep), .watchdogReset(src[4]), .resetInstruction(src[3]), .stackOverflow(src[2]),
      .stackUnderflow(src[1]), .programmingExit(src[0]), .monitorEnable(monEn), .clearPinOut(), .clearPinOe(),
      .clearPinPullup(), .clearPinGpio(), .coreReset(coreReset));
   rsbc_supply_model pm (.clk(clk), .powerOn(powerOn), .dipDepth(dip), .pinLow(pinLow), .monitorEnable(monEn),
      .powerGoodIn(pg), .supplyBelowLowLvlIn(bLow), .supplyBelowHighLvlIn(bHigh), .monitorReadyIn(rdy),
      .externalClearPinIn(pin));
   task endSim;
      $display("checks %0d mismatches %0d", nChecks, nFail);
      if (nFail == 0 && nChecks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nChecks++;
      if (g !== e) begin
         nFail++;
         $display("Error %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   task expRst(input string nm, input int n, input logic e);
      hold(n);
      chk(nm, {31'h0, e}, {31'h0, coreReset});
   endtask
   // Caller enters just after a rising edge; one idle edge follows each transfer
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task waitRun(output int n);
      n = 0;
      while (coreReset !== 1'b0 && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk("release", 0, {31'h0, coreReset});
   endtask
   task tPowerUp;
      int n;
      expRst("unpowered", 20, 1'b1);
      powerOn <= 1'b1;
      waitRun(n);
      chk("power-up delay", 1, n >= 20 + `RSBC_CLEAR_RELEASE_CYC);
      apb(1'b0, CTRL, 32'h0);
      chk("control at start", 32'h81, rd);
   endtask
   task tBrownOut;
      int n;
      dip <= 2'h2;
      hold(12);
      dip <= 2'h0;
      expRst("short dip", 30, 1'b0);
      dip <= 2'h1;
      expRst("above low level", 40, 1'b0);
      lvl <= 1'b1;
      expRst("below high level", 30, 1'b1);
      dip <= 2'h0;
      pwrDis <= 1'b1;
      waitRun(n);
      chk("no delay", 1, n < 20);
      pwrDis <= 1'b0;
   endtask
   task tSleep;
      int n;
      mode <= 2'h2;
      sleep <= 1'b1;
      dip <= 2'h2;
      expRst("sleep unprotected", 40, 1'b0);
      sleep <= 1'b0;
      expRst("awake protected", 40, 1'b1);
      dip <= 2'h0;
      waitRun(n);
      dip <= 2'h2;
      hold(12);
      dip <= 2'h0;
      expRst("awake short dip", 30, 1'b0);
   endtask
   task tSoft;
      int n;
      mode <= 2'h1;
      apb(1'b1, CTRL, 32'h0);
      apb(1'b0, CTRL, 32'h0);
      chk("software off", 32'h0, rd);
      dip <= 2'h2;
      expRst("off no reset", 40, 1'b0);
      dip <= 2'h0;
      apb(1'b1, CTRL, 32'h81);
      apb(1'b0, CTRL, 32'h0);
      chk("not yet ready", 32'h80, rd);
      hold(20);
      apb(1'b0, CTRL, 32'h0);
      chk("ready", 32'h81, rd);
      dip <= 2'h2;
      expRst("on resets", 40, 1'b1);
      dip <= 2'h0;
      waitRun(n);
      mode <= 2'h0;
      apb(1'b1, CTRL, 32'h0);
      apb(1'b0, CTRL, 32'h0);
      chk("enable clear", 32'h0, rd);
      apb(1'b1, CTRL, 32'h81);
      apb(1'b0, CTRL, 32'h0);
      chk("enable inert", 32'h80, rd);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped err", 1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
   endtask
   task tPin;
      int n;
      pinLow <= 1'b1;
      hold(3);
      pinLow <= 1'b0;
      expRst("short pulse", 20, 1'b0);
      pinLow <= 1'b1;
      expRst("pin held", 60, 1'b1);
      pinLow <= 1'b0;
      waitRun(n);
      chk("run after pin", 1, n >= 10 && n <= 18);
      clrEn <= 1'b0;
      pull <= 1'b1;
      pinLow <= 1'b1;
      expRst("pin disabled", 30, 1'b0);
      low_voltage_programming_cfg <= 1'b1;
      expRst("pin by lvp", 30, 1'b1);
      pinLow <= 1'b0;
      waitRun(n);
   endtask
   task tSources;
      int n;
      for (int i = 0; i < 5; i++) begin
         src <= 5'h01 << i;
         @(posedge clk);
         src <= 5'h00;
         expRst("source", 1, 1'b1);
         waitRun(n);
      end
      apb(1'b0, `RSBC_ADDR_RESET_CAUSE, 32'h0);
      chk("reset cause", 32'h0A, rd);
   endtask
   initial begin
      hold(10);
      rst <= 1'b0;
      tPowerUp;
      tBrownOut;
      tSleep;
      tSoft;
      tPin;
      tSources;
      endSim;
   end
   initial begin
      hold(6000);
      nFail++;
      $display("Error watchdog expected finish seen timeout");
      endSim;
   end
endmodule // tb
